/* core/vidc_pkg.sv */
// Package of constants and types for the voltage-select decode and transition block
package vidc_pkg;
    // Code width and reference scale: reference held in units of 6.25 mV
    localparam int          CODE_W      = 8;
    localparam int          REF_W       = 8;
    // Code of the 0.50000 V point, not a clamp: higher codes lower the reference further; codes with bits 7..1 high are off codes
    localparam logic [7:0]  CODE_LOWEST = 8'hb2;
    localparam logic [6:0]  OFF_PREFIX  = 7'h7f;
    // Reference in steps: 0.50000 V is 80 steps, code 0 would be 80 + 0xb2 = 258 steps
    localparam logic [8:0]  REF_AT_ZERO = 9'h102;
    // Boot target 1.10000 V = 176 steps
    localparam logic [7:0]  REF_BOOT    = 8'hb0;
    // Trip settings: overcurrent scale in percent of nominal
    localparam logic [7:0]  OC_NOMINAL  = 8'h64;
    localparam logic [7:0]  OC_RAISED   = 8'hf0;   // nominal + 140 %
    // Overvoltage trip: tracking vs forced maximum
    localparam logic [7:0]  REF_MAX     = 8'hff;
    // Reset values and times
    localparam int          CLK_HZ      = 10_000_000;
    localparam int          BOOT_US     = 85;
    localparam int          BOOT_CYC    = (BOOT_US * (CLK_HZ / 1_000_000));
    localparam int          RDY_US      = 85;
    localparam int          RDY_CYC     = (RDY_US * (CLK_HZ / 1_000_000));
    localparam int          TICK_DIV    = 16;   // soft-start tick period, cycles

    // Controller states
    typedef enum logic [2:0] {
        ST_RAMP_BOOT = 3'b000,
        ST_HOLD_BOOT = 3'b001,
        ST_RAMP_CODE = 3'b010,
        ST_WAIT_RDY  = 3'b011,
        ST_RUN       = 3'b100,
        ST_OFF       = 3'b101
    } vidc_state_t;
endpackage

/* core/vidc_ramp_if.sv */
// Interface between the controller and the reference ramp stepper
`timescale 1ns/1ns
interface vidc_ramp_if;
    logic [7:0] target;
    logic [7:0] level;
    logic       tick;
    logic       atTarget;
    logic       moving;
    modport ctrl (output target, output tick, input level, input atTarget, input moving);
    modport ramp (input target, input tick, output level, output atTarget, output moving);
endinterface

/* core/vidc_ramp.sv */
// Reference stepper: moves the reference one 6.25 mV step per tick toward its target
`timescale 1ns/1ns
module vidc_ramp (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Controller side
    vidc_ramp_if.ramp rp
);
    typedef struct packed {
        logic [7:0] level;
    } vidc_ramp_st_t;

    vidc_ramp_st_t cur;
    vidc_ramp_st_t next_cur;

    // One step per tick, never overshooting, so the reference level has no jumps
    always_comb begin
        next_cur = cur;
        if (rp.tick && cur.level < rp.target) begin
            next_cur.level = cur.level + 8'h01;
        end else if (rp.tick && cur.level > rp.target) begin
            next_cur.level = cur.level - 8'h01;
        end
    end

    // Reference starts from zero at power-up
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rp.level    = cur.level;
    assign rp.atTarget = (cur.level == rp.target);
    assign rp.moving   = (cur.level != rp.target);
endmodule

/* core/vidc_top.sv */
// Voltage-select decode, reference transition and protection threshold control
// Operation
// - Code decodes MSB first; each code step lowers target 6.25 mV, no clamp at 0.50 V.
// - Off code seen after boot shuts down until supply or enable cycles.
// - Code watched while regulating; reference moves to new code without jumps.
// - During a transition or up step the overcurrent trip is raised 140 percent.
// - During a transition the overvoltage trip sits at its maximum level.
// - Transition begun with low-power hint asserted forces all phases until done.
// - After that transition the hint again chooses reduced or full phases.
// - Before regulator-ok is released the hint is ignored; full phases run.
// - Digital ramps move the reference 6.25 mV per soft-start tick.
`timescale 1ns/1ns
module vidc_top #(
    parameter int BOOT_CYC = vidc_pkg::BOOT_CYC,
    parameter int RDY_CYC  = vidc_pkg::RDY_CYC,
    parameter int TICK_DIV = vidc_pkg::TICK_DIV
) (
    // Clock and reset (reset = power-on or enable removal)
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Processor inputs
    input  wire logic [7:0] voltSelect,
    input  wire logic       lowPowerHint_n,
    // Regulator outputs
    output logic [7:0]      refLevel,
    output logic [7:0]      ocTripScale,
    output logic [7:0]      ovTripLevel,
    output logic            allPhasesOn,
    output logic            regulatorOk,
    output logic            shutdown,
    output logic            inTransition
);
    initial begin
        if (BOOT_CYC < 1 || BOOT_CYC > 65535 || RDY_CYC < 1 || RDY_CYC > 65535
            || TICK_DIV < 1 || TICK_DIV > 65535) begin
            $error("vidc_top: timing parameter out of range");
        end
    end

    typedef struct packed {
        vidc_pkg::vidc_state_t state;
        logic [15:0]           timer;
        logic [15:0]           tickCnt;
        logic [7:0]            target;
        logic [7:0]            refLevel;
        logic [7:0]            ocTrip;
        logic [7:0]            ovTrip;
        logic                  forceAll;
        logic                  allOn;
        logic                  ok;
        logic                  off;
        logic                  trans;
    } vidc_top_st_t;

    vidc_top_st_t cur;
    vidc_top_st_t next_cur;
    vidc_ramp_if  rp ();

    logic       isOff;
    logic [7:0] codeRef;
    logic [8:0] codeRefWide;
    logic       tickNow;
    logic       upStep;

    // Code decode: higher code gives lower reference, off codes flagged
    assign isOff       = (voltSelect[7:1] == vidc_pkg::OFF_PREFIX);
    assign codeRefWide = vidc_pkg::REF_AT_ZERO - {1'b0, voltSelect};
    assign codeRef     = (voltSelect > vidc_pkg::CODE_LOWEST) ?
                         codeRefWide[7:0] : codeRefWide[7:0];
    assign tickNow     = (cur.tickCnt == 16'(TICK_DIV - 1));
    assign upStep      = (cur.target > rp.level);

    assign rp.target = cur.target;
    assign rp.tick   = tickNow;

    vidc_ramp u_ramp (
        .mclk   (mclk),
        .resetn (resetn),
        .rp     (rp.ramp)
    );

    // Sequencer: boot ramp, hold, read code, ramp to code, ready delay, run
    always_comb begin
        next_cur          = cur;
        next_cur.tickCnt  = tickNow ? 16'h0000 : cur.tickCnt + 16'h0001;
        next_cur.refLevel = rp.level;
        case (cur.state)
            vidc_pkg::ST_RAMP_BOOT: begin
                next_cur.target = vidc_pkg::REF_BOOT;
                if (rp.atTarget && cur.target == vidc_pkg::REF_BOOT) begin
                    next_cur.state = vidc_pkg::ST_HOLD_BOOT;
                    next_cur.timer = 16'h0000;
                end
            end
            vidc_pkg::ST_HOLD_BOOT: begin
                next_cur.timer = cur.timer + 16'h0001;
                if (cur.timer == 16'(BOOT_CYC - 1)) begin
                    if (isOff) begin
                        next_cur.state = vidc_pkg::ST_OFF;
                    end else begin
                        next_cur.state  = vidc_pkg::ST_RAMP_CODE;
                        next_cur.target = codeRef;
                    end
                end
            end
            vidc_pkg::ST_RAMP_CODE: begin
                if (rp.atTarget) begin
                    next_cur.state = vidc_pkg::ST_WAIT_RDY;
                    next_cur.timer = 16'h0000;
                end
            end
            vidc_pkg::ST_WAIT_RDY: begin
                next_cur.timer = cur.timer + 16'h0001;
                if (cur.timer == 16'(RDY_CYC - 1)) begin
                    next_cur.state = vidc_pkg::ST_RUN;
                end
            end
            vidc_pkg::ST_RUN: begin
                if (isOff) begin
                    next_cur.state = vidc_pkg::ST_OFF;
                end else begin
                    next_cur.target = codeRef;
                end
            end
            vidc_pkg::ST_OFF: begin
                next_cur.target = cur.target;   // Latched: only reset leaves here
            end
            default: begin
                next_cur.state = vidc_pkg::ST_OFF;
            end
        endcase

        // Transition in progress while the reference chases a new code in run
        next_cur.trans = (cur.state == vidc_pkg::ST_RUN) && rp.moving;
        // Protection thresholds relax during transitions and up steps
        next_cur.ocTrip = (next_cur.trans || (cur.state == vidc_pkg::ST_RUN && upStep)) ?
                          vidc_pkg::OC_RAISED : vidc_pkg::OC_NOMINAL;
        next_cur.ovTrip = next_cur.trans ? vidc_pkg::REF_MAX : rp.level;
        // Hint sampled at transition start pins all phases on until done
        if (!next_cur.trans) begin
            next_cur.forceAll = 1'b0;
        end else if (!cur.trans && !lowPowerHint_n) begin
            next_cur.forceAll = 1'b1;
        end
        next_cur.ok    = (next_cur.state == vidc_pkg::ST_RUN);
        // Hint ignored until ready; otherwise hint decides phase count
        next_cur.allOn = !cur.ok || next_cur.forceAll || lowPowerHint_n;
        next_cur.off   = (next_cur.state == vidc_pkg::ST_OFF);
        if (next_cur.off) begin
            next_cur.ok    = 1'b0;
            next_cur.allOn = 1'b0;
        end
    end

    // State register; defined idle values at reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cur       <= '0;
            cur.state <= vidc_pkg::ST_RAMP_BOOT;
            cur.allOn <= 1'b1;
            cur.ocTrip <= vidc_pkg::OC_NOMINAL;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from state flops
    assign refLevel     = cur.refLevel;
    assign ocTripScale  = cur.ocTrip;
    assign ovTripLevel  = cur.ovTrip;
    assign allPhasesOn  = cur.allOn;
    assign regulatorOk  = cur.ok;
    assign shutdown     = cur.off;
    assign inTransition = cur.trans;
endmodule

/* test/vidc_checker.sv */
// Checker of reference steps, trip points and phase control
`timescale 1ns/1ns
module vidc_checker (
    // Clock, reset, processor lines and regulator outputs
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic [7:0] voltSelect,
    input wire logic       lowPowerHint_n,
    input wire logic [7:0] refLevel,
    input wire logic [7:0] ocTripScale,
    input wire logic [7:0] ovTripLevel,
    input wire logic       allPhasesOn,
    input wire logic       regulatorOk,
    input wire logic       shutdown,
    input wire logic       inTransition
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Trips and phases follow the transition flag; wrap-safe step test
    property p_step; refLevel - $past(refLevel) + 8'h01 <= 8'h02; endproperty
    a_step: assert property (p_step) else $error("ref jump");
    property p_oc; inTransition |-> ocTripScale == 8'hf0; endproperty
    a_oc: assert property (p_oc) else $error("oc trip");
    property p_ov; inTransition |-> ovTripLevel == 8'hff; endproperty
    a_ov: assert property (p_ov) else $error("ov trip");
    property p_all; inTransition && $past(inTransition) |-> allPhasesOn; endproperty
    a_all: assert property (p_all) else $error("phases dropped");
    property p_boot; !regulatorOk && !shutdown |-> allPhasesOn; endproperty
    a_boot: assert property (p_boot) else $error("hint early");
    property p_hint; (regulatorOk && !inTransition && $stable(lowPowerHint_n))[*3]
        |-> allPhasesOn == lowPowerHint_n; endproperty
    a_hint: assert property (p_hint) else $error("hint ignored");
    property p_off; regulatorOk && voltSelect[7:1] == 7'h7f |-> ##[1:2] shutdown; endproperty
    a_off: assert property (p_off) else $error("off missed");
    property p_stay; shutdown |=> shutdown && !regulatorOk; endproperty
    a_stay: assert property (p_stay) else $error("off left");
endmodule
bind vidc_top vidc_checker chk (.*);

/* test/vidc_cpu_model.sv */
// Processor model: hint follows the bench, code steps one code per gap
`timescale 1ns/1ns
module vidc_cpu_model (
    // Requests from the bench, lines to the block
    input  wire logic       mclk,
    input  wire logic [7:0] goal,
    input  wire logic       hintIn_n,
    output logic [7:0]      code = 8'h50,
    output logic            hint_n = 1'b0
);
    int cnt = 0;
    // Off codes switch at once; voltage codes walk slowly so each step settles
    always @(negedge mclk) begin
        hint_n <= hintIn_n;
        cnt <= (cnt + 1) % 7;
        if (goal[7:1] == 7'h7f || code[7:1] == 7'h7f) code <= goal;
        else if (cnt == 0 && code != goal) code <= code + (code < goal ? 8'h01 : 8'hff);
    end
endmodule

/* test/voltage_id_decode_and_transition_bench.sv */
// Bench: boot, code steps with the hint, off codes, resets
`timescale 1ns/1ns
module voltage_id_decode_and_transition_bench;
    logic       mclk = 1'b0, resetn, hintIn_n, lowPowerHint_n, allPhasesOn;
    logic       regulatorOk, shutdown, inTransition;
    logic [7:0] goal = 8'h50, voltSelect, refLevel, ocTripScale, ovTripLevel;
    int         n_errors = 0, num_checks = 0, t, q[$], g0;
    vidc_cpu_model cpu (.mclk, .goal, .hintIn_n, .code(voltSelect), .hint_n(lowPowerHint_n));
    vidc_top #(.BOOT_CYC(4), .RDY_CYC(4), .TICK_DIV(2)) DUT (.*);
    initial forever #50 mclk = ~mclk; // Clock
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (t >= 3000) n_errors++; // An expired wait is a mismatch
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Reset, boot with the hint asserted, reduced phases once ready
    task automatic boot;
        resetn = 1'b0;
        hintIn_n = 1'b0;
        repeat (8) @(negedge mclk);
        resetn = 1'b1;
        for (t = 0; t < 3000 && regulatorOk !== 1'b1; t++) @(negedge mclk);
        if (t >= 3000) report_and_stop();
        repeat (3) @(negedge mclk);
        check(refLevel, 8'(258 - goal));
        check(allPhasesOn, 8'h00);
        $display("boot %h ok", goal);
    endtask
    // Step to a new code: phases during, reference and trip after
    task automatic walk(input logic [7:0] g, input logic h);
        if (g == voltSelect) g = g ^ 8'h01;
        @(negedge mclk);
        goal = g;
        hintIn_n = h;
        for (t = 0; t < 3000 && inTransition !== 1'b1; t++) @(negedge mclk);
        if (t >= 3000) report_and_stop();
        check(allPhasesOn, 8'h01);
        check(ocTripScale, 8'hf0);
        check(ovTripLevel, 8'hff);
        for (t = 0; t < 3000 && (voltSelect !== g || inTransition !== 1'b0); t++) @(negedge mclk);
        if (t >= 3000) report_and_stop();
        repeat (8) @(negedge mclk);
        check(refLevel, 8'(258 - g));
        check(ovTripLevel, 8'(258 - g));
        check(allPhasesOn, {7'h00, h});
        check(ocTripScale, 8'h64);
        $display("walk %h ok", g);
    endtask
    // Fixed and random steps, then both off codes, each followed by a reset
    initial begin
        t = $urandom(6931);
        boot();
        q = '{8'h4e, 8'hb2};
        repeat (4) q.push_back($urandom_range(177, 16));
        // Pop first: argument evaluation order is not fixed by the language
        while (q.size() > 0) begin
            g0 = q.pop_front();
            walk(8'(g0), q.size() % 2 == 0);
        end
        for (int k = 0; k < 2; k++) begin
            @(negedge mclk);
            goal = 8'hfe + 8'(k);
            @(negedge mclk);
            goal = 8'h40;
            repeat (30) @(negedge mclk);
            check(shutdown, 8'h01);
            $display("off %0d ok", k);
            boot();
        end
        report_and_stop();
    end
endmodule
